/* bls_pkg.sv */
// Purpose: Shared constants and types for the boot link selector
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes: Debug register addresses are word indices on the debug port
package bls_pkg;
  // Clock and serial rates
  localparam int CLK_HZ = 10_000_000;
  localparam int START_BPS = 9600;
  localparam int LIMIT_BPS = 6_000_000;
  localparam logic [15:0] START_DIV = 16'((CLK_HZ + START_BPS / 2) / START_BPS);
  localparam logic [15:0] MIN_DIV = 16'h0002;
  localparam int MAX_BPS_CALC = CLK_HZ / 2;
  localparam logic [31:0] MAX_RATE =
    32'((MAX_BPS_CALC < LIMIT_BPS) ? MAX_BPS_CALC : LIMIT_BPS);
  localparam logic [3:0] UART_FRAME_BITS = 4'hA;
  localparam logic [3:0] UART_DATA_BITS = 4'h8;
  // Setup protocol bytes
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ACK_BYTE = 8'h00;
  localparam logic [7:0] GENERIC_CODE = 8'h55;
  localparam logic [7:0] BOOT_CODE = 8'hC6;
  localparam logic [7:0] MAGIC_CODE = 8'hA5;
  localparam logic [1:0] ZERO_RUN = 2'h3;
  localparam logic [4:0] INIT_CYCLES = 5'h10;
  // Debug port register indices
  localparam logic [2:0] IDX_RX_DATA = 3'h0;
  localparam logic [2:0] IDX_TX_DATA = 3'h1;
  localparam logic [2:0] IDX_STATUS = 3'h2;
  localparam logic [2:0] IDX_MODE = 3'h3;
  localparam logic [2:0] IDX_DBG_STATUS = 3'h4;
  localparam int STS_RXFULL_BIT = 0;
  localparam int STS_TXEMPTY_BIT = 1;
  localparam int DBG_PWRREQ_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] WORD_BYTES = 3'h4;
  // USB function description
  localparam logic [7:0] USB_CLASS_COMM = 8'h02;
  localparam logic [7:0] USB_SUB_ACM = 8'h02;
  localparam logic [7:0] USB_PROTO_AT = 8'h01;
  localparam logic [3:0] EP_CONTROL = 4'h0;
  localparam logic [3:0] EP_BULK_IN = 4'h1;
  localparam logic [3:0] EP_BULK_OUT = 4'h2;
  localparam logic [3:0] EP_INT_IN = 4'h6;
  localparam logic [6:0] BULK_MAX_PKT = 7'h40;

  typedef enum logic [1:0] {LNK_NONE, LNK_UART, LNK_USB, LNK_MBOX} bls_link_t;
  typedef enum logic [2:0] {
    ST_INIT, ST_HUNT, ST_ACK, ST_WAITGEN, ST_BOOT, ST_CMD
  } bls_state_t;
  typedef enum logic [1:0] {PH_INIT, PH_SETUP, PH_CMD} bls_phase_t;
  typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} bls_urx_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [31:0] wdata;
  } bls_dbg_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic [7:0] data;
  } bls_usb_byte_t;

  typedef struct packed {
    logic fullSpeed;
    logic selfPowered;
    logic [7:0] devClass;
    logic [7:0] subClass;
    logic [7:0] protocol;
    logic [3:0] ctrlEp;
    logic [3:0] bulkInEp;
    logic [3:0] bulkOutEp;
    logic [3:0] intInEp;
    logic [6:0] bulkMaxPkt;
  } bls_usb_cfg_t;

  localparam bls_usb_cfg_t USB_CFG = '{1'b1, 1'b1, USB_CLASS_COMM, USB_SUB_ACM,
    USB_PROTO_AT, EP_CONTROL, EP_BULK_IN, EP_BULK_OUT, EP_INT_IN, BULK_MAX_PKT};
endpackage : bls_pkg

/* bls_uart.sv */
// Purpose: Pin synchroniser and 8N1 serial transceiver
// Assumes: Divisor is cycles per bit, at least two
// Notes: Data goes least significant bit first
`timescale 1ns/1ps
`default_nettype none

module bls_sync #(parameter int W = 1)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // Two flops, first one feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : bls_sync

module bls_uart #(parameter int DIV_W = 16)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rxPin,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic txPin
);
  logic rxLine;
  bls_pkg::bls_urx_t rxSt_r, rxSt_nxt;
  logic [DIV_W-1:0] rxCnt_r, rxCnt_nxt, txCnt_r, txCnt_nxt;
  logic [3:0] rxBit_r, rxBit_nxt, txLeft_r, txLeft_nxt;
  logic [7:0] rxSh_r, rxSh_nxt;
  logic rxValid_nxt;
  logic [9:0] txFrame_r, txFrame_nxt;
  logic txBusy_r, txBusy_nxt, txPin_nxt;

  bls_sync #(.W(1)) uRxSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(rxPin),
    .dout(rxLine)
  );

  // Receiver: sample mid-bit, check start and stop
  always_comb
  begin
    rxSt_nxt = rxSt_r;
    rxCnt_nxt = rxCnt_r;
    rxBit_nxt = rxBit_r;
    rxSh_nxt = rxSh_r;
    rxValid_nxt = 1'b0;
    unique case (rxSt_r)
      bls_pkg::U_IDLE:
        if (!rxLine)
        begin
          rxSt_nxt = bls_pkg::U_START;
          rxCnt_nxt = divisor >> 1;
        end
      bls_pkg::U_START:
        if (rxCnt_r != '0)
          rxCnt_nxt = rxCnt_r - 1'b1;
        else if (!rxLine)
        begin
          rxSt_nxt = bls_pkg::U_DATA;
          rxCnt_nxt = divisor - 1'b1;
          rxBit_nxt = '0;
        end
        else
          rxSt_nxt = bls_pkg::U_IDLE;
      bls_pkg::U_DATA:
        if (rxCnt_r != '0)
          rxCnt_nxt = rxCnt_r - 1'b1;
        else
        begin
          rxSh_nxt = {rxLine, rxSh_r[7:1]}; // [R1]
          rxCnt_nxt = divisor - 1'b1;
          rxBit_nxt = rxBit_r + 1'b1;
          if (rxBit_r == bls_pkg::UART_DATA_BITS - 1'b1)
            rxSt_nxt = bls_pkg::U_STOP;
        end
      bls_pkg::U_STOP:
        if (rxCnt_r != '0)
          rxCnt_nxt = rxCnt_r - 1'b1;
        else
        begin
          rxValid_nxt = rxLine; // Framing error drops the byte
          rxSt_nxt = bls_pkg::U_IDLE;
        end
    endcase
  end

  // Transmitter: start, 8 data, 1 stop shifted from one frame
  always_comb
  begin
    txFrame_nxt = txFrame_r;
    txCnt_nxt = txCnt_r;
    txLeft_nxt = txLeft_r;
    txBusy_nxt = txBusy_r;
    txPin_nxt = txPin;
    if (!txBusy_r)
    begin
      if (txValid)
      begin
        txFrame_nxt = {1'b1, txData, 1'b0}; // [R1]
        txPin_nxt = 1'b0;
        txCnt_nxt = divisor - 1'b1;
        txLeft_nxt = bls_pkg::UART_FRAME_BITS;
        txBusy_nxt = 1'b1;
      end
    end
    else if (txCnt_r != '0)
      txCnt_nxt = txCnt_r - 1'b1;
    else if (txLeft_r == 4'h1)
    begin
      txBusy_nxt = 1'b0;
      txPin_nxt = 1'b1;
    end
    else
    begin
      txFrame_nxt = txFrame_r >> 1;
      txPin_nxt = txFrame_r[1];
      txLeft_nxt = txLeft_r - 1'b1;
      txCnt_nxt = divisor - 1'b1;
    end
  end

  // State registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rxSt_r <= bls_pkg::U_IDLE;
      rxCnt_r <= '0;
      rxBit_r <= '0;
      rxSh_r <= '0;
      rxValid <= 1'b0;
      rxData <= '0;
      txFrame_r <= '1;
      txCnt_r <= '0;
      txLeft_r <= '0;
      txBusy_r <= 1'b0;
      txPin <= 1'b1;
      txReady <= 1'b0;
    end
    else
    begin
      rxSt_r <= rxSt_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxBit_r <= rxBit_nxt;
      rxSh_r <= rxSh_nxt;
      rxValid <= rxValid_nxt;
      rxData <= rxValid_nxt ? rxSh_nxt : rxData;
      txFrame_r <= txFrame_nxt;
      txCnt_r <= txCnt_nxt;
      txLeft_r <= txLeft_nxt;
      txBusy_r <= txBusy_nxt;
      txPin <= txPin_nxt;
      txReady <= !txBusy_nxt;
    end
  end
endmodule : bls_uart
`default_nettype wire

/* bls_top.sv */
// Purpose: Boot link selection, setup handshake and mailbox byte transfer
// Assumes: USB protocol engine, debug port and command parser on sys_clk
// Notes: Pins pass two flops; the rest is same-clock logic
`timescale 1ns/1ps
`default_nettype none

//Contract
// [R1] UART starts 9600 bps, 8N1, LSB first
// [R2] Switch UART rate after rate-change completes
// [R3] Report maximum UART rate supported
// [R4] USB link is full speed
// [R5] USB function is CDC ACM, AT
// [R6] Endpoints 0 control, 1/2 bulk, 6 interrupt
// [R7] USB reports self-powered
// [R8] Host writes magic during terminal reset
// [R9] Host bytes unpacked from word, LSB first
// [R10] Device packs outgoing bytes, LSB first
// [R11] Host checks receive-full before writing
// [R12] Host checks transmit-empty before reading
// [R13] Accept back-to-back mailbox accesses
// [R14] Phases: init, setup, command, fixed order
// [R15] Init finishes then enters setup
// [R16] Command phase only after generic code
// [R17] Three UART zero bytes select UART
// [R18] Three USB zero bytes select USB
// [R19] Power request, magic, boot pin select mailbox
// [R20] Zero count restarts on other data
// [R21] Ack 00h, generic 55h, boot code C6h
// [R22] Mailbox waits generic code only
// [R23] Other links ignored after selection
module bls_top
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic termResetPin,
  input wire logic bootModePin,
  input wire logic uartRxPin,
  output logic uartTxPin,
  input wire bls_pkg::bls_dbg_req_t dbgReq,
  output logic [31:0] dbgRdata,
  input wire bls_pkg::bls_usb_byte_t usbRx,
  input wire logic usbTxReady,
  output logic usbTxValid,
  output logic [3:0] usbTxEp,
  output logic [7:0] usbTxData,
  output bls_pkg::bls_usb_cfg_t usbCfg,
  input wire logic cmdTxValid,
  input wire logic [7:0] cmdTxData,
  input wire logic cmdTxFlush,
  output logic cmdTxReady,
  output logic cmdRxValid,
  output logic [7:0] cmdRxData,
  input wire logic rateChangeDone,
  input wire logic [15:0] rateDivisor,
  output bls_pkg::bls_phase_t phase,
  output bls_pkg::bls_link_t linkSel,
  output logic [31:0] maxRateField
);
  logic termRst, bootMode;
  logic uRxV, uTxReady, uTxValid;
  logic [7:0] uRxD;
  bls_pkg::bls_state_t st_r, st_nxt;
  bls_pkg::bls_link_t link_r, link_nxt, zeroLink_r, zeroLink_nxt;
  logic [1:0] zeroCnt_r, zeroCnt_nxt;
  logic [4:0] initCnt_r, initCnt_nxt;
  logic [15:0] div_r, div_nxt;
  logic [7:0] pend_r, pend_nxt, modeReg_r, modeReg_nxt;
  logic pendV_r, pendV_nxt, pwrReq_r, pwrReq_nxt, pwrInRst_r, pwrInRst_nxt;
  logic [31:0] rxHold_r, rxHold_nxt, rxWork_r, rxWork_nxt;
  logic rxFull_r, rxFull_nxt;
  logic [2:0] rxLeft_r, rxLeft_nxt, txCnt_r, txCnt_nxt;
  logic [31:0] txPack_r, txPack_nxt, txOut_r, txOut_nxt, rdata_nxt;
  logic txOutFull_r, txOutFull_nxt, flush_r, flush_nxt;
  logic usbV_nxt, cmdRxV_nxt;
  logic [7:0] usbD_nxt, cmdRxD_nxt;
  logic evV, mbV, usbV, sendIdle, moveWord;
  logic [7:0] evD;

  // True when a debug write or read hits register index idx
  function automatic logic hit(input bls_pkg::bls_dbg_req_t r,
                               input logic [2:0] idx, input logic isWr);
    hit = (isWr ? r.wr : r.rd) && (r.addr == idx);
  endfunction : hit

  bls_sync #(.W(2)) uPinSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din({termResetPin, bootModePin}),
    .dout({termRst, bootMode})
  );

  bls_uart #(.DIV_W(16)) uUart (
    .sys_clk(sys_clk),
    .rst(rst),
    .rxPin(uartRxPin),
    .divisor(div_r),
    .txValid(uTxValid),
    .txData(pend_r),
    .txReady(uTxReady),
    .rxValid(uRxV),
    .rxData(uRxD),
    .txPin(uartTxPin)
  );

  // Byte sources and the byte of the selected link
  assign usbV = usbRx.valid && (usbRx.ep == bls_pkg::EP_BULK_OUT); // [R6]
  assign mbV = rxLeft_r != 3'h0;
  assign uTxValid = pendV_r && (link_r == bls_pkg::LNK_UART);
  assign moveWord = rxFull_r && !mbV;
  always_comb
  begin
    evV = 1'b0;
    evD = 8'h00;
    unique case (link_r) // [R23]
      bls_pkg::LNK_UART:
      begin
        evV = uRxV;
        evD = uRxD;
      end
      bls_pkg::LNK_USB:
      begin
        evV = usbV;
        evD = usbRx.data;
      end
      bls_pkg::LNK_MBOX:
      begin
        evV = mbV;
        evD = rxWork_r[7:0];
      end
      bls_pkg::LNK_NONE:
      begin
        evV = 1'b0;
        evD = 8'h00;
      end
    endcase
  end

  // Sender is idle when nothing queued or still on the wire
  always_comb
  begin
    unique case (link_r)
      bls_pkg::LNK_UART: sendIdle = !pendV_r && uTxReady;
      bls_pkg::LNK_USB: sendIdle = !pendV_r && !usbTxValid;
      bls_pkg::LNK_MBOX: sendIdle = !pendV_r && txCnt_r == 3'h0 && !flush_r;
      bls_pkg::LNK_NONE: sendIdle = !pendV_r;
    endcase
  end

  // Phase sequencer and link selection
  always_comb
  begin
    st_nxt = st_r;
    link_nxt = link_r;
    zeroCnt_nxt = zeroCnt_r;
    zeroLink_nxt = zeroLink_r;
    initCnt_nxt = initCnt_r;
    div_nxt = div_r;
    cmdRxV_nxt = 1'b0;
    cmdRxD_nxt = cmdRxData;
    unique case (st_r)
      bls_pkg::ST_INIT:
        if (termRst)
          initCnt_nxt = 5'h00;
        else if (initCnt_r == bls_pkg::INIT_CYCLES - 1'b1)
          st_nxt = bls_pkg::ST_HUNT; // [R14] [R15]
        else
          initCnt_nxt = initCnt_r + 1'b1;
      bls_pkg::ST_HUNT:
        if (pwrInRst_r && modeReg_r == bls_pkg::MAGIC_CODE && bootMode)
        begin
          link_nxt = bls_pkg::LNK_MBOX; // [R19]
          st_nxt = bls_pkg::ST_WAITGEN; // [R22]
        end
        else if (uRxV && usbV)
          zeroCnt_nxt = 2'h0; // [R20]
        else if (uRxV || usbV)
        begin
          zeroLink_nxt = uRxV ? bls_pkg::LNK_UART : bls_pkg::LNK_USB;
          if ((uRxV ? uRxD : usbRx.data) != bls_pkg::ZERO_BYTE)
            zeroCnt_nxt = 2'h0; // [R20]
          else if (zeroLink_r != zeroLink_nxt)
            zeroCnt_nxt = 2'h1; // [R20]
          else
            zeroCnt_nxt = zeroCnt_r + 1'b1;
          if (zeroCnt_nxt == bls_pkg::ZERO_RUN)
          begin
            link_nxt = zeroLink_nxt; // [R17] [R18]
            st_nxt = bls_pkg::ST_ACK;
          end
        end
      bls_pkg::ST_ACK:
        st_nxt = bls_pkg::ST_WAITGEN; // [R21]
      bls_pkg::ST_WAITGEN:
        if (evV && evD == bls_pkg::GENERIC_CODE)
          st_nxt = bls_pkg::ST_BOOT; // [R21] [R22]
      bls_pkg::ST_BOOT:
        if (sendIdle && !pendV_r)
          st_nxt = bls_pkg::ST_CMD; // [R16]
      bls_pkg::ST_CMD:
      begin
        cmdRxV_nxt = evV;
        cmdRxD_nxt = evV ? evD : cmdRxData;
        if (rateChangeDone)
          div_nxt = (rateDivisor < bls_pkg::MIN_DIV) ?
                    bls_pkg::MIN_DIV : rateDivisor; // [R2]
      end
    endcase
  end

  // Outgoing byte queue and link drivers
  always_comb
  begin
    pend_nxt = pend_r;
    pendV_nxt = pendV_r;
    usbV_nxt = usbTxValid;
    usbD_nxt = usbTxData;
    txPack_nxt = txPack_r;
    txCnt_nxt = txCnt_r;
    txOut_nxt = txOut_r;
    txOutFull_nxt = txOutFull_r;
    flush_nxt = flush_r || (st_r == bls_pkg::ST_CMD && cmdTxFlush);
    if (usbTxValid && usbTxReady)
      usbV_nxt = 1'b0;
    if (hit(dbgReq, bls_pkg::IDX_TX_DATA, 1'b0))
      txOutFull_nxt = 1'b0;
    if (pendV_r)
      unique case (link_r)
        bls_pkg::LNK_UART:
          pendV_nxt = !uTxReady;
        bls_pkg::LNK_USB:
          if (!usbTxValid)
          begin
            usbV_nxt = 1'b1;
            usbD_nxt = pend_r;
            pendV_nxt = 1'b0;
          end
        bls_pkg::LNK_MBOX:
          if (txCnt_r != bls_pkg::WORD_BYTES)
          begin
            txPack_nxt[8*txCnt_r[1:0] +: 8] = pend_r; // [R10]
            txCnt_nxt = txCnt_r + 1'b1;
            pendV_nxt = 1'b0;
            flush_nxt = flush_nxt || st_r == bls_pkg::ST_BOOT;
          end
        bls_pkg::LNK_NONE:
          pendV_nxt = 1'b0;
      endcase
    // Full or flushed word goes to the host-readable register
    if ((txCnt_r == bls_pkg::WORD_BYTES || (flush_r && txCnt_r != 3'h0)) &&
        !txOutFull_r)
    begin
      txOut_nxt = txPack_r; // [R10]
      txOutFull_nxt = 1'b1;
      // A byte packed in the same cycle opens the next word
      txPack_nxt[7:0] = pend_r;
      txCnt_nxt = {2'h0, pendV_r && !pendV_nxt};
      flush_nxt = 1'b0;
    end
    else if (flush_r && txCnt_r == 3'h0 && !pendV_r)
      flush_nxt = 1'b0;
    if (!pendV_nxt)
    begin
      if (st_r == bls_pkg::ST_ACK)
      begin
        pend_nxt = bls_pkg::ACK_BYTE; // [R21]
        pendV_nxt = 1'b1;
      end
      else if (st_r == bls_pkg::ST_WAITGEN && st_nxt == bls_pkg::ST_BOOT)
      begin
        pend_nxt = bls_pkg::BOOT_CODE; // [R21]
        pendV_nxt = 1'b1;
      end
      else if (st_r == bls_pkg::ST_CMD && cmdTxValid && cmdTxReady)
      begin
        pend_nxt = cmdTxData;
        pendV_nxt = 1'b1;
      end
    end
  end

  // Debug port registers and mailbox receive path
  always_comb
  begin
    modeReg_nxt = modeReg_r;
    pwrReq_nxt = pwrReq_r;
    rxHold_nxt = rxHold_r;
    rxWork_nxt = rxWork_r;
    rxLeft_nxt = rxLeft_r;
    rdata_nxt = dbgRdata;
    if (hit(dbgReq, bls_pkg::IDX_MODE, 1'b1))
      modeReg_nxt = dbgReq.wdata[7:0]; // [R8]
    if (hit(dbgReq, bls_pkg::IDX_DBG_STATUS, 1'b1))
      pwrReq_nxt = dbgReq.wdata[bls_pkg::DBG_PWRREQ_BIT];
    pwrInRst_nxt = termRst ? pwrReq_nxt : pwrInRst_r; // [R19]
    if (mbV)
    begin
      rxWork_nxt = rxWork_r >> 8; // [R9]
      rxLeft_nxt = rxLeft_r - 1'b1;
    end
    if (moveWord)
    begin
      rxWork_nxt = rxHold_r;
      rxLeft_nxt = (st_r == bls_pkg::ST_CMD) ? bls_pkg::WORD_BYTES : 3'h1;
    end
    if (link_r != bls_pkg::LNK_MBOX)
      rxLeft_nxt = 3'h0; // [R23]
    if (hit(dbgReq, bls_pkg::IDX_RX_DATA, 1'b1))
      rxHold_nxt = dbgReq.wdata; // [R9] [R13]
    rxFull_nxt = hit(dbgReq, bls_pkg::IDX_RX_DATA, 1'b1) ||
                 (rxFull_r && !moveWord); // [R11]
    if (dbgReq.rd)
      unique case (dbgReq.addr)
        bls_pkg::IDX_RX_DATA: rdata_nxt = rxHold_r;
        bls_pkg::IDX_TX_DATA: rdata_nxt = txOut_r; // [R12] [R13]
        bls_pkg::IDX_STATUS:
        begin
          rdata_nxt = 32'h0000_0000;
          rdata_nxt[bls_pkg::STS_RXFULL_BIT] = rxFull_r; // [R11]
          rdata_nxt[bls_pkg::STS_TXEMPTY_BIT] = !txOutFull_r; // [R12]
        end
        bls_pkg::IDX_MODE: rdata_nxt = {24'h000000, modeReg_r};
        bls_pkg::IDX_DBG_STATUS: rdata_nxt = {31'h0, pwrReq_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
  end

  // Register stage
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= bls_pkg::ST_INIT;
      link_r <= bls_pkg::LNK_NONE;
      zeroLink_r <= bls_pkg::LNK_NONE;
      zeroCnt_r <= 2'h0;
      initCnt_r <= 5'h00;
      div_r <= bls_pkg::START_DIV; // [R1]
      pend_r <= 8'h00;
      pendV_r <= 1'b0;
      modeReg_r <= bls_pkg::MODE_RESET;
      pwrReq_r <= 1'b0;
      pwrInRst_r <= 1'b0;
      rxHold_r <= 32'h0000_0000;
      rxWork_r <= 32'h0000_0000;
      rxFull_r <= 1'b0;
      rxLeft_r <= 3'h0;
      txPack_r <= 32'h0000_0000;
      txCnt_r <= 3'h0;
      txOut_r <= 32'h0000_0000;
      txOutFull_r <= 1'b0;
      flush_r <= 1'b0;
      dbgRdata <= 32'h0000_0000;
      usbTxValid <= 1'b0;
      usbTxEp <= bls_pkg::EP_BULK_IN; // [R6]
      usbTxData <= 8'h00;
      usbCfg <= bls_pkg::USB_CFG; // [R4] [R5] [R6] [R7]
      cmdTxReady <= 1'b0;
      cmdRxValid <= 1'b0;
      cmdRxData <= 8'h00;
      phase <= bls_pkg::PH_INIT;
      linkSel <= bls_pkg::LNK_NONE;
      maxRateField <= bls_pkg::MAX_RATE; // [R3]
    end
    else
    begin
      st_r <= st_nxt;
      link_r <= link_nxt;
      zeroLink_r <= zeroLink_nxt;
      zeroCnt_r <= zeroCnt_nxt;
      initCnt_r <= initCnt_nxt;
      div_r <= div_nxt;
      pend_r <= pend_nxt;
      pendV_r <= pendV_nxt;
      modeReg_r <= modeReg_nxt;
      pwrReq_r <= pwrReq_nxt;
      pwrInRst_r <= pwrInRst_nxt;
      rxHold_r <= rxHold_nxt;
      rxWork_r <= rxWork_nxt;
      rxFull_r <= rxFull_nxt;
      rxLeft_r <= rxLeft_nxt;
      txPack_r <= txPack_nxt;
      txCnt_r <= txCnt_nxt;
      txOut_r <= txOut_nxt;
      txOutFull_r <= txOutFull_nxt;
      flush_r <= flush_nxt;
      dbgRdata <= rdata_nxt;
      usbTxValid <= usbV_nxt;
      usbTxEp <= bls_pkg::EP_BULK_IN;
      usbTxData <= usbD_nxt;
      usbCfg <= bls_pkg::USB_CFG;
      cmdTxReady <= st_nxt == bls_pkg::ST_CMD && !pendV_nxt;
      cmdRxValid <= cmdRxV_nxt;
      cmdRxData <= cmdRxD_nxt;
      phase <= (st_nxt == bls_pkg::ST_INIT) ? bls_pkg::PH_INIT :
               (st_nxt == bls_pkg::ST_CMD) ? bls_pkg::PH_CMD :
               bls_pkg::PH_SETUP; // [R14]
      linkSel <= link_nxt;
      maxRateField <= bls_pkg::MAX_RATE;
    end
  end
endmodule : bls_top
`default_nettype wire

/* bls_host_model.sv */
// Purpose: Host end of the serial link, 8N1 frames at a set divisor
// Assumes: Caller orders frames; line idles high through a pull-up
// Notes: Bits change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none

module bls_host_model
(
  input wire logic sys_clk,
  input wire logic [15:0] divisor,
  input wire logic lineIn,
  output logic lineOut
);
  // Pulled-up idle level
  initial lineOut = 1'b1;

  // One frame: start, data LSB first, one stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge sys_clk) lineOut = f[i];
      repeat (divisor - 16'h0001) @(negedge sys_clk);
    end
  endtask : send

  // Sample each data bit mid-way after the start edge
  task automatic recv(output logic [7:0] b);
    @(negedge lineIn);
    repeat (divisor / 16'h0002) @(negedge sys_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (divisor) @(negedge sys_clk);
      b[i] = lineIn;
    end
  endtask : recv
endmodule : bls_host_model

`default_nettype wire

/* bls_top_asserts.sv */
// Purpose: Port checks for the boot link selector
// Assumes: Bound into bls_top, one clock domain
// Notes: Attempts spanning a reset are dropped
`timescale 1ns/1ps
`default_nettype none

module bls_top_asserts
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic uartTxPin,
  input wire logic cmdTxReady,
  input wire logic cmdRxValid,
  input wire bls_pkg::bls_usb_cfg_t usbCfg,
  input wire bls_pkg::bls_phase_t phase,
  input wire bls_pkg::bls_link_t linkSel,
  input wire logic [31:0] maxRateField
);
  // Clock and reset shared by all properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Constant descriptors
  property p_cfg; usbCfg == bls_pkg::USB_CFG; endproperty
  a_cfg: assert property (p_cfg)
    else $error("usb config wrong");
  property p_rate; maxRateField == bls_pkg::MAX_RATE; endproperty
  a_rate: assert property (p_rate)
    else $error("max rate wrong");
  // Phase sequencing
  property p_order;
    !$past(rst) && $changed(phase) |->
      phase != bls_pkg::PH_INIT && phase == $past(phase) + 1;
  endproperty
  a_order: assert property (p_order)
    else $error("phase order broken");
  property p_ready; cmdTxReady |-> phase == bls_pkg::PH_CMD; endproperty
  a_ready: assert property (p_ready)
    else $error("tx ready outside command phase");
  property p_rxcmd; cmdRxValid |-> phase == bls_pkg::PH_CMD; endproperty
  a_rxcmd: assert property (p_rxcmd)
    else $error("rx byte outside command phase");
  property p_link;
    phase == bls_pkg::PH_CMD |-> linkSel != bls_pkg::LNK_NONE;
  endproperty
  a_link: assert property (p_link)
    else $error("command phase without link");
  property p_stick;
    linkSel != bls_pkg::LNK_NONE |=> $stable(linkSel);
  endproperty
  a_stick: assert property (p_stick)
    else $error("link changed after selection");
  property p_idle; phase == bls_pkg::PH_INIT |-> uartTxPin; endproperty
  a_idle: assert property (p_idle)
    else $error("serial line not idle in init");

  // Main scenarios
  c_uart: cover property (phase == bls_pkg::PH_CMD
    && linkSel == bls_pkg::LNK_UART);
  c_mbox: cover property (phase == bls_pkg::PH_CMD
    && linkSel == bls_pkg::LNK_MBOX);
  c_rx: cover property (cmdRxValid);
endmodule : bls_top_asserts

bind bls_top bls_top_asserts bls_top_asserts_i (.sys_clk, .rst, .uartTxPin,
  .cmdTxReady, .cmdRxValid, .usbCfg, .phase, .linkSel, .maxRateField);

`default_nettype wire

/* tb_bls_top.sv */
// Purpose: Self-checking bench for the boot link selector
// Assumes: Host model on the serial pins, bench drives the debug port
// Notes: Mailbox boot first, then serial boot after a second reset
`timescale 1ns/1ps
`default_nettype none

module tb_bls_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic termResetPin = 1'b1;
  logic bootModePin = 1'b1;
  logic uartRxPin, uartTxPin, usbTxValid, cmdTxReady, cmdRxValid;
  logic cmdTxValid = 1'b0;
  logic [7:0] cmdTxData = 8'h00;
  logic [7:0] usbTxData, cmdRxData, b;
  logic [3:0] usbTxEp;
  logic [31:0] dbgRdata, maxRateField, w, rd;
  bls_pkg::bls_dbg_req_t dbgReq = '0;
  bls_pkg::bls_usb_byte_t usbRx = '0;
  bls_pkg::bls_usb_cfg_t usbCfg;
  bls_pkg::bls_phase_t phase;
  bls_pkg::bls_link_t linkSel;
  logic [7:0] rxq[$];
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  bls_top bls_top_i (.sys_clk, .rst, .termResetPin, .bootModePin,
    .uartRxPin, .uartTxPin, .dbgReq, .dbgRdata, .usbRx,
    .usbTxReady(1'b1), .usbTxValid, .usbTxEp, .usbTxData, .usbCfg,
    .cmdTxValid, .cmdTxData, .cmdTxFlush(1'b0), .cmdTxReady, .cmdRxValid,
    .cmdRxData, .rateChangeDone(1'b0), .rateDivisor(16'h0000), .phase,
    .linkSel, .maxRateField);
  bls_host_model bls_host_model_i (.sys_clk,
    .divisor(bls_pkg::START_DIV), .lineIn(uartTxPin), .lineOut(uartRxPin));

  // Clock
  initial forever #50 sys_clk = ~sys_clk;

  // Byte capture and hang guard
  always @(negedge sys_clk)
  begin
    cyc++;
    if (cmdRxValid === 1'b1) rxq.push_back(cmdRxData);
    if (cyc == 90000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic check(input string nm, input logic [31:0] exp, act);
    tests_run++;
    if (act !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, act);
    end
  endtask : check

  // One debug port access, read data kept in rd
  task automatic dbg(input logic wr, input logic [2:0] a,
    input logic [31:0] d);
    @(negedge sys_clk) dbgReq = '{wr, ~wr, a, d};
    @(negedge sys_clk) dbgReq = '0;
    rd = dbgRdata;
  endtask : dbg

  // Hand one byte to the device for sending
  task automatic cmdSend(input logic [7:0] d);
    @(negedge sys_clk) {cmdTxValid, cmdTxData} = {1'b1, d};
    while (cmdTxReady !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk) cmdTxValid = 1'b0;
  endtask : cmdSend

  task automatic waitCmd;
    for (int i = 0; i < 3000 && phase !== bls_pkg::PH_CMD; i++)
      @(negedge sys_clk);
  endtask : waitCmd

  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // Main sequence
  initial
  begin
    void'($urandom(32'h58380dff));
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    dbg(1'b1, bls_pkg::IDX_DBG_STATUS, 32'h1);
    dbg(1'b1, bls_pkg::IDX_MODE, 32'hA5);
    @(negedge sys_clk) termResetPin = 1'b0;
    repeat (40) @(negedge sys_clk);
    check("link", bls_pkg::LNK_MBOX, linkSel);
    check("phase", bls_pkg::PH_SETUP, phase);
    w = $urandom;
    dbg(1'b1, bls_pkg::IDX_RX_DATA, {w[31:8], 8'h12});
    repeat (4) @(negedge sys_clk);
    dbg(1'b0, bls_pkg::IDX_STATUS, '0);
    check("status", 32'h2, rd);
    dbg(1'b1, bls_pkg::IDX_RX_DATA, {w[31:8], bls_pkg::GENERIC_CODE});
    repeat (4) @(negedge sys_clk);
    dbg(1'b0, bls_pkg::IDX_STATUS, '0);
    check("status", 32'h0, rd);
    dbg(1'b0, bls_pkg::IDX_TX_DATA, '0);
    check("boot", bls_pkg::BOOT_CODE, rd[7:0]);
    waitCmd();
    check("phase", bls_pkg::PH_CMD, phase);
    dbg(1'b0, 3'h7, '0);
    check("unmapped", 32'h0, rd);
    // Command phase words both ways, no flag checks
    rxq = {};
    dbg(1'b1, bls_pkg::IDX_RX_DATA, w);
    repeat (8) @(negedge sys_clk);
    check("nrx", 32'd4, rxq.size());
    foreach (rxq[i]) check("rxbyte", w[8*i +: 8], rxq[i]);
    for (int i = 0; i < 4; i++) cmdSend(~w[8*i +: 8]);
    repeat (4) @(negedge sys_clk);
    dbg(1'b0, bls_pkg::IDX_TX_DATA, '0);
    check("txword", ~w, rd);
    // Serial boot after a second reset
    @(negedge sys_clk) {rst, termResetPin, bootModePin} = 3'b100;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (40) @(negedge sys_clk);
    @(negedge sys_clk) usbRx = '{1'b1, bls_pkg::EP_BULK_OUT, 8'h00};
    repeat (2) @(negedge sys_clk);
    usbRx = '0;
    b = 8'($urandom_range(255, 1));
    bls_host_model_i.send(8'h00);
    bls_host_model_i.send(b);
    bls_host_model_i.send(8'h00);
    bls_host_model_i.send(8'h00);
    check("link", bls_pkg::LNK_NONE, linkSel);
    fork
      bls_host_model_i.send(bls_pkg::ZERO_BYTE);
      bls_host_model_i.recv(b);
    join
    check("ack", bls_pkg::ACK_BYTE, b);
    check("link", bls_pkg::LNK_UART, linkSel);
    fork
      bls_host_model_i.send(bls_pkg::GENERIC_CODE);
      bls_host_model_i.recv(b);
    join
    check("boot", bls_pkg::BOOT_CODE, b);
    waitCmd();
    check("phase", bls_pkg::PH_CMD, phase);
    check("ep", bls_pkg::EP_BULK_IN, usbTxEp);
    results();
  end
endmodule : tb_bls_top

`default_nettype wire
